// >>> logic/rtc_time_calendar_counters.sv
// serial-bus time and calendar counter bank with supply-integrity flag
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// R1 - seconds BCD 00-59, tens bits 6:4
// R2 - seconds bit 7 supply-low flag, starts set
// R3 - low supply sets flag until host clears
// R4 - oscillator stop also sets the flag
// R5 - minutes BCD 00-59, bit 7 unused
// R6 - hours 24-hour BCD, bits 7:6 unused
// R7 - day of month BCD, bits 7:6 unused
// R8 - February 29 when year divisible by four
// R9 - weekday binary 0-6 in bits 2:0
// R10 - month BCD 01-12, bits 6:5 unused
// R11 - century bit toggles on year 99 to 00
// R12 - years BCD 00-99 in full byte
// R13 - counters frozen during serial access
// R14 - one deferred tick applied after access
// R15 - host finishes each access within one second
// R16 - host accesses all time registers together
// R17 - host reads from pointer 02h, seven bytes
// R18 - halt bit clears divider, stops counting
// R19 - tick carries through all calendar counters
// R20 - pointer advances after every data byte
module rtc_time_calendar_counters #(
  parameter int DIV_COUNT = rtc_pkg::XTAL_HZ,
  parameter int TIMEOUT_CYC = rtc_pkg::OSC_TIMEOUT_CYC
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rstn_in,
  // serial bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  // crystal and supply monitor
  input wire logic xtal_in,
  input wire logic supply_low_in,
  // status
  output logic supply_low_flag_out,
  output logic access_active_out
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [2:0] pin_raw;
  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;
  logic [2:0] sync3_reg;
  logic [2:0] filt_reg;
  logic [2:0] filt_d_reg;
  logic scl_f, scl_d, sda_f, sda_d, low_f;
  logic scl_rise, scl_fall, start_cond, stop_cond;

  rtc_pkg::serial_state_t state_reg;
  logic [3:0] cnt_reg;
  logic [7:0] shift_reg;
  logic [3:0] ptr_reg;
  logic rw_reg;
  logic nack_reg;
  logic busy_reg;

  logic wr_stb;
  logic rd_load;
  logic [7:0] rd_data;

  logic low_flag_reg;
  logic halt_reg;
  logic pending_reg;
  logic tick;
  logic osc_stopped;
  logic tick_apply;

  logic [6:0] sec_reg, sec_next;
  logic [6:0] min_reg, min_next;
  logic [5:0] hour_reg, hour_next;
  logic [5:0] day_reg, day_next;
  logic [2:0] wday_reg, wday_next;
  logic [4:0] month_reg, month_next;
  logic century_reg, century_next;
  logic [7:0] year_reg, year_next;

  // ----------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    logic [7:0] r;
    r = v;
    if (v[3:0] == 4'h9) begin
      r = {v[7:4] + 4'h1, 4'h0};
    end else begin
      r = {v[7:4], v[3:0] + 4'h1};
    end
    return r;
  endfunction

  // year counter in BCD is a multiple of four, 00 included
  function automatic logic leap_year(input logic [7:0] y);
    logic r;
    r = 1'b0;
    if (!y[4]) begin
      r = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
    end else begin
      r = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
    end
    return r;
  endfunction

  function automatic logic [5:0] last_day(input logic [4:0] m, input logic [7:0] y);
    logic [5:0] r;
    r = 6'h31;
    case (m)
      5'h02: r = leap_year(y) ? 6'h29 : 6'h28; // see R8
      5'h04, 5'h06, 5'h09, 5'h11: r = 6'h30;
      default: r = 6'h31;
    endcase
    return r;
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  assign pin_raw = {supply_low_in, sda_in, scl_in};

  // a change counts once the second and third stages agree
  generate
    for (genvar i = 0; i < 3; i++) begin : g_sync
      always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
          sync1_reg[i] <= 1'b1;
          sync2_reg[i] <= 1'b1;
          sync3_reg[i] <= 1'b1;
          filt_reg[i] <= 1'b1;
          filt_d_reg[i] <= 1'b1;
        end else begin
          sync1_reg[i] <= pin_raw[i];
          sync2_reg[i] <= sync1_reg[i];
          sync3_reg[i] <= sync2_reg[i];
          if (sync2_reg[i] == sync3_reg[i]) begin
            filt_reg[i] <= sync3_reg[i];
          end
          filt_d_reg[i] <= filt_reg[i];
        end
      end
    end
  endgenerate

  assign scl_f = filt_reg[0];
  assign scl_d = filt_d_reg[0];
  assign sda_f = filt_reg[1];
  assign sda_d = filt_d_reg[1];
  assign low_f = filt_reg[2];

  assign scl_rise = scl_f && !scl_d;
  assign scl_fall = !scl_f && scl_d;
  assign start_cond = scl_f && scl_d && sda_d && !sda_f;
  assign stop_cond = scl_f && scl_d && !sda_d && sda_f;

  // ----------------------------------------------------------------
  // register read mux
  // ----------------------------------------------------------------
  always_comb begin
    rd_data = 8'h00;
    case (ptr_reg)
      rtc_pkg::CTRL1_ADDR: rd_data[rtc_pkg::HALT_BIT] = halt_reg;
      rtc_pkg::SEC_ADDR: rd_data = {low_flag_reg, sec_reg}; // see R1, R2
      rtc_pkg::MIN_ADDR: rd_data = {1'b0, min_reg}; // see R5
      rtc_pkg::HOUR_ADDR: rd_data = {2'b00, hour_reg}; // see R6
      rtc_pkg::DAY_ADDR: rd_data = {2'b00, day_reg}; // see R7
      rtc_pkg::WDAY_ADDR: rd_data = {5'h00, wday_reg}; // see R9
      rtc_pkg::MONTH_ADDR: rd_data = {century_reg, 2'b00, month_reg}; // see R10
      rtc_pkg::YEAR_ADDR: rd_data = year_reg; // see R12
      default: rd_data = 8'h00;
    endcase
  end

  assign wr_stb = (state_reg == rtc_pkg::ST_WRITE) && scl_fall && (cnt_reg == 4'h8);
  assign rd_load = scl_fall && (((state_reg == rtc_pkg::ST_ADDR_ACK) && rw_reg) ||
                   ((state_reg == rtc_pkg::ST_READ_ACK) && !nack_reg));

  // ----------------------------------------------------------------
  // serial slave engine
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      state_reg <= rtc_pkg::ST_IDLE;
      cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      ptr_reg <= 4'h0;
      rw_reg <= 1'b0;
      nack_reg <= 1'b0;
      busy_reg <= 1'b0;
      sda_oe_out <= 1'b0;
    end else if (stop_cond) begin
      state_reg <= rtc_pkg::ST_IDLE;
      busy_reg <= 1'b0; // see R14
      sda_oe_out <= 1'b0;
    end else if (start_cond) begin
      state_reg <= rtc_pkg::ST_ADDR;
      cnt_reg <= 4'h0;
      sda_oe_out <= 1'b0;
    end else if (rd_load) begin
      shift_reg <= rd_data;
      ptr_reg <= ptr_reg + 4'h1; // see R20
      sda_oe_out <= !rd_data[7];
      cnt_reg <= 4'h0;
      state_reg <= rtc_pkg::ST_READ;
    end else begin
      case (state_reg)
        rtc_pkg::ST_ADDR, rtc_pkg::ST_PTR, rtc_pkg::ST_WRITE: begin
          if (scl_rise) begin
            shift_reg <= {shift_reg[6:0], sda_f};
            cnt_reg <= cnt_reg + 4'h1;
          end else if (scl_fall && (cnt_reg == 4'h8)) begin
            sda_oe_out <= 1'b1;
            if (state_reg == rtc_pkg::ST_ADDR) begin
              if (shift_reg[7:1] == rtc_pkg::SLAVE_ADDR) begin
                rw_reg <= shift_reg[0];
                busy_reg <= 1'b1; // see R13
                state_reg <= rtc_pkg::ST_ADDR_ACK;
              end else begin
                sda_oe_out <= 1'b0;
                busy_reg <= 1'b0;
                state_reg <= rtc_pkg::ST_IDLE;
              end
            end else if (state_reg == rtc_pkg::ST_PTR) begin
              ptr_reg <= shift_reg[3:0];
              state_reg <= rtc_pkg::ST_PTR_ACK;
            end else begin
              ptr_reg <= ptr_reg + 4'h1; // see R20
              state_reg <= rtc_pkg::ST_WRITE_ACK;
            end
          end
        end
        rtc_pkg::ST_ADDR_ACK, rtc_pkg::ST_PTR_ACK, rtc_pkg::ST_WRITE_ACK: begin
          if (scl_fall) begin
            sda_oe_out <= 1'b0;
            cnt_reg <= 4'h0;
            state_reg <= (state_reg == rtc_pkg::ST_ADDR_ACK) ?
                         rtc_pkg::ST_PTR : rtc_pkg::ST_WRITE;
          end
        end
        rtc_pkg::ST_READ: begin
          if (scl_rise) begin
            cnt_reg <= cnt_reg + 4'h1;
          end else if (scl_fall) begin
            if (cnt_reg == 4'h8) begin
              sda_oe_out <= 1'b0;
              state_reg <= rtc_pkg::ST_READ_ACK;
            end else begin
              shift_reg <= {shift_reg[6:0], 1'b0};
              sda_oe_out <= !shift_reg[6];
            end
          end
        end
        rtc_pkg::ST_READ_ACK: begin
          if (scl_rise) begin
            nack_reg <= sda_f;
          end else if (scl_fall) begin
            // master refused more data: wait for stop, access still open
            state_reg <= rtc_pkg::ST_IDLE;
          end
        end
        default: begin
          sda_oe_out <= 1'b0;
        end
      endcase
    end
  end

  // open-drain: only ever pull low
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      sda_out <= 1'b0;
      access_active_out <= 1'b0;
    end else begin
      sda_out <= 1'b0;
      access_active_out <= busy_reg;
    end
  end

  // ----------------------------------------------------------------
  // control and supply-integrity flag
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      halt_reg <= rtc_pkg::HALT_RST;
    end else if (wr_stb && (ptr_reg == rtc_pkg::CTRL1_ADDR)) begin
      halt_reg <= shift_reg[rtc_pkg::HALT_BIT]; // see R18
    end
  end

  // a detection in the clearing cycle wins over the host's clear
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      low_flag_reg <= rtc_pkg::LOW_FLAG_RST; // see R2
    end else if (low_f || osc_stopped) begin
      low_flag_reg <= 1'b1; // see R3, R4
    end else if (wr_stb && (ptr_reg == rtc_pkg::SEC_ADDR)) begin
      low_flag_reg <= shift_reg[rtc_pkg::LOW_FLAG_BIT]; // see R3
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      supply_low_flag_out <= rtc_pkg::LOW_FLAG_RST;
    end else begin
      supply_low_flag_out <= low_flag_reg;
    end
  end

  // ----------------------------------------------------------------
  // tick source and deferred tick
  // ----------------------------------------------------------------
  one_hz_divider #(
    .DIV_COUNT(DIV_COUNT),
    .TIMEOUT_CYC(TIMEOUT_CYC)
  ) u_divider (
    .mclk_in(mclk_in),
    .rstn_in(rstn_in),
    .xtal_in(xtal_in),
    .halt_in(halt_reg),
    .tick_out(tick),
    .osc_stopped_out(osc_stopped)
  );

  assign tick_apply = !busy_reg && !halt_reg && (tick || pending_reg); // see R13, R18

  // only one tick can wait; a second during one access is lost
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      pending_reg <= 1'b0;
    end else if (busy_reg) begin
      pending_reg <= pending_reg || tick; // see R14
    end else if (!halt_reg) begin
      // running: the waiting tick is applied now and clears, unless a new tick arrives in the same cycle
      pending_reg <= pending_reg && tick;
    end
  end

  // ----------------------------------------------------------------
  // calendar increment
  // ----------------------------------------------------------------
  always_comb begin
    sec_next = sec_reg;
    min_next = min_reg;
    hour_next = hour_reg;
    day_next = day_reg;
    wday_next = wday_reg;
    month_next = month_reg;
    century_next = century_reg;
    year_next = year_reg;
    if (tick_apply) begin
      sec_next = 7'(bcd_inc({1'b0, sec_reg})); // see R19
      if (sec_reg == 7'h59) begin
        sec_next = 7'h00;
        min_next = 7'(bcd_inc({1'b0, min_reg}));
        if (min_reg == 7'h59) begin
          min_next = 7'h00;
          hour_next = 6'(bcd_inc({2'b00, hour_reg}));
          if (hour_reg == 6'h23) begin
            hour_next = 6'h00;
            wday_next = (wday_reg == 3'h6) ? 3'h0 : wday_reg + 3'h1;
            day_next = 6'(bcd_inc({2'b00, day_reg}));
            if (day_reg == last_day(month_reg, year_reg)) begin
              day_next = 6'h01;
              month_next = 5'(bcd_inc({3'b000, month_reg}));
              if (month_reg == 5'h12) begin
                month_next = 5'h01;
                year_next = bcd_inc(year_reg);
                if (year_reg == 8'h99) begin
                  year_next = 8'h00;
                  century_next = !century_reg; // see R11
                end
              end
            end
          end
        end
      end
    end
  end

  // host writes arrive only while busy, when the increment is frozen
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      sec_reg <= rtc_pkg::SEC_RST;
      min_reg <= rtc_pkg::MIN_RST;
      hour_reg <= rtc_pkg::HOUR_RST;
      day_reg <= rtc_pkg::DAY_RST;
      wday_reg <= rtc_pkg::WDAY_RST;
      month_reg <= rtc_pkg::MONTH_RST;
      century_reg <= rtc_pkg::CENTURY_RST;
      year_reg <= rtc_pkg::YEAR_RST;
    end else if (wr_stb) begin
      case (ptr_reg)
        rtc_pkg::SEC_ADDR: sec_reg <= shift_reg[6:0];
        rtc_pkg::MIN_ADDR: min_reg <= shift_reg[6:0];
        rtc_pkg::HOUR_ADDR: hour_reg <= shift_reg[5:0];
        rtc_pkg::DAY_ADDR: day_reg <= shift_reg[5:0];
        rtc_pkg::WDAY_ADDR: wday_reg <= shift_reg[2:0];
        rtc_pkg::MONTH_ADDR: begin
          month_reg <= shift_reg[4:0];
          century_reg <= shift_reg[rtc_pkg::CENTURY_BIT];
        end
        rtc_pkg::YEAR_ADDR: year_reg <= shift_reg;
        default: sec_reg <= sec_reg;
      endcase
    end else begin
      sec_reg <= sec_next;
      min_reg <= min_next;
      hour_reg <= hour_next;
      day_reg <= day_next;
      wday_reg <= wday_next;
      month_reg <= month_next;
      century_reg <= century_next;
      year_reg <= year_next;
    end
  end

endmodule
`default_nettype wire

// >>> pkg/rtc_pkg.sv
// constants and types shared by the time and calendar counter bank
package rtc_pkg;

  // ----------------------------------------------------------------
  // serial bus identity and register pointer map
  // ----------------------------------------------------------------
  localparam logic [6:0] SLAVE_ADDR = 7'h51;
  localparam logic [3:0] CTRL1_ADDR = 4'h0;
  localparam logic [3:0] CTRL2_ADDR = 4'h1;
  localparam logic [3:0] SEC_ADDR = 4'h2;
  localparam logic [3:0] MIN_ADDR = 4'h3;
  localparam logic [3:0] HOUR_ADDR = 4'h4;
  localparam logic [3:0] DAY_ADDR = 4'h5;
  localparam logic [3:0] WDAY_ADDR = 4'h6;
  localparam logic [3:0] MONTH_ADDR = 4'h7;
  localparam logic [3:0] YEAR_ADDR = 4'h8;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int HALT_BIT = 5;
  localparam int LOW_FLAG_BIT = 7;
  localparam int CENTURY_BIT = 7;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic LOW_FLAG_RST = 1'b1;
  localparam logic HALT_RST = 1'b0;
  localparam logic [6:0] SEC_RST = 7'h00;
  localparam logic [6:0] MIN_RST = 7'h00;
  localparam logic [5:0] HOUR_RST = 6'h00;
  localparam logic [5:0] DAY_RST = 6'h01;
  localparam logic [2:0] WDAY_RST = 3'h0;
  localparam logic [4:0] MONTH_RST = 5'h01;
  localparam logic CENTURY_RST = 1'b0;
  localparam logic [7:0] YEAR_RST = 8'h00;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 25_000_000;
  localparam int XTAL_HZ = 32_768;
  localparam int OSC_TIMEOUT_NS = 100_000;
  localparam int OSC_TIMEOUT_CYC = (OSC_TIMEOUT_NS * (CLK_HZ / 1_000_000)) / 1_000;

  // ----------------------------------------------------------------
  // serial engine states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_PTR,
    ST_PTR_ACK,
    ST_WRITE,
    ST_WRITE_ACK,
    ST_READ,
    ST_READ_ACK
  } serial_state_t;

endpackage

// >>> logic/one_hz_divider.sv
// crystal divider chain producing the 1 Hz tick and an oscillator-stop monitor
`timescale 1ns/1ps
`default_nettype none

module one_hz_divider #(
  parameter int DIV_COUNT = rtc_pkg::XTAL_HZ,
  parameter int TIMEOUT_CYC = rtc_pkg::OSC_TIMEOUT_CYC
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rstn_in,
  // crystal and control
  input wire logic xtal_in,
  input wire logic halt_in,
  // results
  output logic tick_out,
  output logic osc_stopped_out
);

  logic [2:0] xsync_reg;
  logic xfilt_reg;
  logic [15:0] div_reg;
  logic [15:0] idle_reg;
  logic xrise;
  logic xchange;

  // ----------------------------------------------------------------
  // crystal input synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      xsync_reg <= 3'h0;
      xfilt_reg <= 1'b0;
    end else begin
      xsync_reg <= {xsync_reg[1:0], xtal_in};
      if (xsync_reg[1] == xsync_reg[2]) begin
        xfilt_reg <= xsync_reg[2];
      end
    end
  end

  assign xchange = (xsync_reg[1] == xsync_reg[2]) && (xsync_reg[2] != xfilt_reg);
  assign xrise = xchange && xsync_reg[2];

  // ----------------------------------------------------------------
  // divider chain
  // ----------------------------------------------------------------
  // synchronous clear stands in for the asynchronous one: halt is a register bit
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      div_reg <= 16'h0000;
      tick_out <= 1'b0;
    end else if (halt_in) begin
      div_reg <= 16'h0000; // see R18
      tick_out <= 1'b0;
    end else begin
      tick_out <= 1'b0;
      if (xrise) begin
        if (div_reg == 16'(DIV_COUNT - 1)) begin
          div_reg <= 16'h0000;
          tick_out <= 1'b1;
        end else begin
          div_reg <= div_reg + 16'h0001;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // oscillator-stop monitor
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      idle_reg <= 16'h0000;
      osc_stopped_out <= 1'b0;
    end else if (xchange) begin
      idle_reg <= 16'h0000;
      osc_stopped_out <= 1'b0;
    end else if (idle_reg == 16'(TIMEOUT_CYC)) begin
      osc_stopped_out <= 1'b1; // see R4
    end else begin
      idle_reg <= idle_reg + 16'h0001;
    end
  end

endmodule
`default_nettype wire

// >>> tb/rtc_host_model.sv
// serial bus host model for the counter bank
`timescale 1ns/1ps
`default_nettype none

module rtc_host_model (
  // clock
  input wire logic mclk_in,
  // bus lines
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_out
);
  // ----
  // bus phases
  // ----
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end
  // whole access stays far below one second
  task automatic tk(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask
  task automatic bus_start();
    sda_out = 1'b1;
    tk(8);
    scl_out = 1'b1;
    tk(8);
    sda_out = 1'b0;
    tk(8);
    scl_out = 1'b0;
  endtask
  task automatic bus_stop();
    tk(3);
    sda_out = 1'b0;
    tk(8);
    scl_out = 1'b1;
    tk(8);
    sda_out = 1'b1;
    tk(8);
  endtask
  // data set up well after the fall, so no false start or stop
  task automatic bit_io(input logic b, output logic r);
    tk(3);
    sda_out = b;
    tk(8);
    scl_out = 1'b1;
    tk(8);
    r = sda_in;
    scl_out = 1'b0;
  endtask
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  task automatic rd_byte(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(nack, r);
  endtask
endmodule

`default_nettype wire

// >>> tb/rtc_time_calendar_counters_asserts.sv
// port-level checker for the counter bank
`timescale 1ns/1ps
`default_nettype none

module rtc_counters_asserts #(
  parameter int TIMEOUT_CYC = rtc_pkg::OSC_TIMEOUT_CYC
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rstn_in,
  // serial bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_out,
  // crystal and supply monitor
  input wire logic xtal_in,
  input wire logic supply_low_in,
  // status
  input wire logic supply_low_flag_out,
  input wire logic access_active_out
);
  // ----
  // helpers
  // ----
  int xcnt_reg;
  int stop_age_reg;
  logic xprev_reg;
  logic sda_prev_reg;
  logic stop_seen;
  assign stop_seen = scl_in && sda_in && !sda_prev_reg;
  always_ff @(posedge mclk_in) begin
    xprev_reg <= xtal_in;
    if (!rstn_in || xtal_in != xprev_reg) xcnt_reg <= 0;
    else if (xcnt_reg < 1000) xcnt_reg <= xcnt_reg + 1;
  end
  always_ff @(posedge mclk_in) begin
    sda_prev_reg <= sda_in;
    if (!rstn_in || stop_seen) stop_age_reg <= 0;
    else if (stop_age_reg < 1000) stop_age_reg <= stop_age_reg + 1;
  end
  // ----
  // properties
  // ----
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rstn_in);
  a_flag_at_reset: assert property ($rose(rstn_in) |-> supply_low_flag_out)
    else $error("flag clear after reset");
  a_low_sets_flag: assert property (supply_low_in [*8] |-> ##[0:4] supply_low_flag_out)
    else $error("low supply did not set flag");
  a_flag_sticky: assert property (supply_low_flag_out && !access_active_out |=> supply_low_flag_out)
    else $error("flag cleared without access");
  a_osc_stop_flag: assert property (xcnt_reg == TIMEOUT_CYC + 12 |-> supply_low_flag_out)
    else $error("stopped crystal did not set flag");
  a_stop_release: assert property (stop_seen |-> ##[1:12] !access_active_out)
    else $error("access not closed after stop");
  a_freeze_hold: assert property ($fell(access_active_out) |-> stop_age_reg <= 12)
    else $error("access closed without stop");
  a_oe_stable: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe_out))
    else $error("data changed while clock high");
  // the status output trails the busy state by one cycle
  a_drive_in_access: assert property (sda_oe_out |=> access_active_out)
    else $error("data driven outside access");
endmodule

`default_nettype wire

// >>> tb/rtc_time_calendar_counters_tb_top.sv
// self-checking bench for the counter bank
`timescale 1ns/1ps
`default_nettype none

module rtc_time_calendar_counters_tb_top;
  localparam int DIVN = 4;
  localparam int TMO = 200;
  logic mclk_in;
  logic rstn;
  logic supply_low;
  logic xtal;
  logic xrun = 1'b0;
  int xpend = 0;
  wire logic scl;
  wire logic host_sda;
  wire logic sda_wire;
  logic sda_o;
  logic sda_oe;
  logic flag;
  logic active;
  int err_total = 0;
  int n_checks = 0;
  logic [7:0] rd_buf [9];
  logic [111:0] rows [9];
  // pull-up wire: low while either the host or the device drives low
  assign sda_wire = host_sda & (sda_o | ~sda_oe);

  rtc_host_model i_host (.mclk_in(mclk_in), .sda_in(sda_wire), .scl_out(scl), .sda_out(host_sda));
  rtc_time_calendar_counters #(.DIV_COUNT(DIVN), .TIMEOUT_CYC(TMO)) i_dut (
    .mclk_in(mclk_in), .rstn_in(rstn), .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_o),
    .sda_oe_out(sda_oe), .xtal_in(xtal), .supply_low_in(supply_low),
    .supply_low_flag_out(flag), .access_active_out(active));

  // ----
  // clock and crystal
  // ----
  initial begin
    mclk_in = 1'b0;
    forever #20 mclk_in = ~mclk_in;
  end
  // free running or a counted number of rises
  initial begin
    xtal = 1'b0;
    forever begin
      i_host.tk(6);
      if (xrun || xpend > 0) begin
        xtal = ~xtal;
        if (xtal && xpend > 0) xpend--;
      end
    end
  end
  initial begin
    repeat (90000) @(posedge mclk_in);
    err_total++;
    stop_test();
  end

  // ----
  // tasks
  // ----
  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk_byte(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic chk_bit(input string nm, input logic exp, input logic got);
    chk_byte(nm, {7'h00, exp}, {7'h00, got});
  endtask
  task automatic send(input logic [7:0] b);
    logic ack;
    i_host.wr_byte(b, ack);
    chk_bit("ack", 1'b1, ack);
  endtask
  task automatic open(input logic [3:0] p);
    i_host.bus_start();
    send(8'hA2);
    send({4'h0, p});
  endtask
  task automatic wr1(input logic [3:0] p, input logic [7:0] b);
    open(p);
    send(b);
    i_host.bus_stop();
  endtask
  task automatic wr9(input logic [71:0] d);
    open(4'h0);
    for (int i = 0; i < 9; i++) send(d[71 - 8 * i -: 8]);
    i_host.bus_stop();
  endtask
  task automatic rd(input logic [3:0] p, input int n);
    open(p);
    i_host.bus_start();
    send(8'hA3);
    for (int i = 0; i < n; i++) i_host.rd_byte(i == n - 1, rd_buf[i]);
    i_host.bus_stop();
  endtask
  task automatic rises(input int n);
    xpend = n;
    for (int i = 0; i < 4000 && xpend > 0; i++) @(posedge mclk_in);
    if (xpend > 0) begin
      err_total++;
      stop_test();
    end
    i_host.tk(20);
  endtask

  // ----
  // sequence
  // ----
  initial begin
    rstn = 1'b0;
    supply_low = 1'b0;
    // start time, then expected time one tick later
    rows[0] = 112'h59_59_23_31_06_12_99_00_00_00_01_00_81_00;
    rows[1] = 112'h59_59_23_28_02_02_04_00_00_00_29_03_02_04;
    rows[2] = 112'h59_59_23_28_02_02_03_00_00_00_01_03_03_03;
    rows[3] = 112'h59_59_23_28_01_02_00_00_00_00_29_02_02_00;
    rows[4] = 112'h59_59_23_30_05_04_25_00_00_00_01_06_05_25;
    rows[5] = 112'h59_59_09_15_02_09_19_00_00_10_15_02_09_19;
    rows[6] = 112'h59_59_23_30_02_09_19_00_00_00_01_03_10_19;
    rows[7] = 112'h59_59_23_31_04_92_99_00_00_00_01_05_01_00;
    rows[8] = 112'h09_41_07_05_03_06_10_10_41_07_05_03_06_10;
    i_host.tk(12);
    rstn = 1'b1;
    i_host.tk(6);
    rd(4'h0, 9);
    for (int i = 0; i < 9; i++) begin
      chk_byte("reset", 8'(72'h00_00_80_00_00_01_00_01_00 >> (64 - 8 * i)), rd_buf[i]);
    end
    chk_bit("flag", 1'b1, flag);
    // halt clears the divider, then exactly one tick
    for (int r = 0; r < 9; r++) begin
      wr9({16'h2000, rows[r][111:56]});
      wr1(4'h0, 8'h00);
      rises(DIVN);
      rd(4'h2, 7);
      chk_byte("sec", {1'b0, rows[r][54:48]}, {1'b0, rd_buf[0][6:0]});
      for (int i = 1; i < 7; i++) begin
        chk_byte("time", rows[r][55 - 8 * i -: 8], rd_buf[i]);
      end
    end
    // two ticks inside one access, only one survives
    open(4'h2);
    rises(2 * DIVN);
    chk_bit("active", 1'b1, active);
    i_host.bus_stop();
    i_host.tk(20);
    rd(4'h2, 7);
    chk_byte("frozen", 8'h11, {1'b0, rd_buf[0][6:0]});
    chk_byte("min", 8'h41, rd_buf[1]);
    // halted with the crystal running
    xrun = 1'b1;
    wr1(4'h0, 8'h20);
    wr1(4'h2, 8'h30);
    i_host.tk(4);
    chk_bit("flag", 1'b0, flag);
    rd(4'h2, 1);
    chk_byte("halted", 8'h30, rd_buf[0]);
    supply_low = 1'b1;
    i_host.tk(20);
    supply_low = 1'b0;
    i_host.tk(20);
    rd(4'h2, 1);
    chk_bit("flag", 1'b1, flag);
    chk_byte("sticky", 8'hB0, rd_buf[0]);
    wr1(4'h2, 8'h30);
    xrun = 1'b0;
    i_host.tk(TMO + 40);
    chk_bit("flag", 1'b1, flag);
    stop_test();
  end
endmodule

bind rtc_time_calendar_counters rtc_counters_asserts #(.TIMEOUT_CYC(TIMEOUT_CYC)) i_chk (
  .mclk_in(mclk_in), .rstn_in(rstn_in), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe_out(sda_oe_out), .xtal_in(xtal_in), .supply_low_in(supply_low_in),
  .supply_low_flag_out(supply_low_flag_out), .access_active_out(access_active_out));

`default_nettype wire
